// *** hw/blae_pkg.sv ***
package blae_pkg;

    // ****************************************
    // instruction word layout
    // ****************************************
    localparam int WORD_W = 14;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 7;
    localparam int OP_HI = 13;
    localparam int OP_LO = 8;
    localparam int DEST_BIT = 7;

    // opcode fields, bits 13:8
    localparam logic [5:0] OP_ADD_WORK_TO_FILE = 6'h07;
    localparam logic [5:0] OP_AND_WORK_WITH_FILE = 6'h05;
    localparam logic [5:0] OP_XOR_WORK_WITH_FILE = 6'h06;
    localparam logic [5:0] OP_XOR_LITERAL_INTO_WORK = 6'h3A;

    // reset values
    localparam logic [7:0] WORK_RESET = 8'h00;
    localparam logic [1:0] PHASE_RESET = 2'h0;

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [1:0] {
        PH_DECODE = 2'b00,
        PH_READ = 2'b01,
        PH_PROCESS = 2'b10,
        PH_WRITE = 2'b11
    } blae_phase_e;

    typedef enum logic [2:0] {
        OPK_NONE = 3'b000,
        OPK_ADD = 3'b001,
        OPK_AND = 3'b010,
        OPK_XORF = 3'b011,
        OPK_XORL = 3'b100
    } blae_op_e;

    // request to the file register port
    typedef struct packed {
        logic rd;
        logic wr;
        logic [6:0] addr;
        logic [7:0] wdata;
    } blae_file_req_s;

    // status flag updates
    typedef struct packed {
        logic carry_we;
        logic carry;
        logic digit_carry_flag_we;
        logic digit_carry_flag;
        logic zero_we;
        logic zero;
    } blae_flags_s;

endpackage

// *** hw/blae_exec.sv ***
`timescale 1ns/1ps

// Contract
// - add_work_to_file sums work and file, routes by dest bit, updates carry, digit carry and zero.
// - and_work_with_file ands work and file, routes by dest bit, updates only zero.
// - xor_literal_into_work xors work with the literal into work, updates only zero.
// - xor_work_with_file xors work and file, routes by dest bit, updates only zero.
module blae_exec (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic [13:0] instr_word,
    input wire logic [7:0] file_rdata,
    output blae_pkg::blae_file_req_s file_req,
    output blae_pkg::blae_flags_s flags_out,
    output logic [7:0] work_out,
    output logic [1:0] phase_out,
    output logic instr_done,
    output logic instr_illegal
);

    // ****************************************
    // reset release
    // ****************************************
    logic rst_meta_reg;
    logic rst_sync_reg;

    // async assert, synchronous release through two flops
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    // ****************************************
    // decode function
    // ****************************************
    function automatic blae_pkg::blae_op_e decode_op(input logic [13:0] w);
        blae_pkg::blae_op_e k;
        k = blae_pkg::OPK_NONE;
        unique case (w[blae_pkg::OP_HI:blae_pkg::OP_LO])
            blae_pkg::OP_ADD_WORK_TO_FILE: k = blae_pkg::OPK_ADD;
            blae_pkg::OP_AND_WORK_WITH_FILE: k = blae_pkg::OPK_AND;
            blae_pkg::OP_XOR_WORK_WITH_FILE: k = blae_pkg::OPK_XORF;
            blae_pkg::OP_XOR_LITERAL_INTO_WORK: k = blae_pkg::OPK_XORL;
            default: k = blae_pkg::OPK_NONE;
        endcase
        return k;
    endfunction

    // ****************************************
    // datapath state
    // ****************************************
    blae_pkg::blae_phase_e phase_reg, phase_next;
    blae_pkg::blae_op_e op_reg, op_next;
    logic dest_reg, dest_next;
    logic [6:0] addr_reg, addr_next;
    logic [7:0] opnd_reg, opnd_next;
    logic [7:0] result_reg, result_next;
    logic carry_reg, carry_next;
    logic dcarry_reg, dcarry_next;
    logic [7:0] work_reg, work_next;
    blae_pkg::blae_file_req_s req_reg, req_next;
    blae_pkg::blae_flags_s flags_reg, flags_next;
    logic done_reg, done_next;
    logic illegal_reg, illegal_next;
    logic [8:0] sum9;
    logic [4:0] sum5;

    // next-state: one phase per clock, four clocks per instruction
    always_comb
    begin
        phase_next = phase_reg;
        op_next = op_reg;
        dest_next = dest_reg;
        addr_next = addr_reg;
        opnd_next = opnd_reg;
        result_next = result_reg;
        carry_next = carry_reg;
        dcarry_next = dcarry_reg;
        work_next = work_reg;
        req_next = '0;
        flags_next = '0;
        done_next = 1'b0;
        illegal_next = 1'b0;
        sum9 = {1'b0, work_reg} + {1'b0, opnd_reg};
        sum5 = {1'b0, work_reg[3:0]} + {1'b0, opnd_reg[3:0]};
        unique case (phase_reg)
            blae_pkg::PH_DECODE:
            begin
                op_next = decode_op(instr_word);
                dest_next = instr_word[blae_pkg::DEST_BIT];
                addr_next = instr_word[blae_pkg::ADDR_W-1:0];
                opnd_next = instr_word[blae_pkg::DATA_W-1:0]; // literal for xor
                req_next.rd = (decode_op(instr_word) != blae_pkg::OPK_NONE)
                    && (decode_op(instr_word) != blae_pkg::OPK_XORL);
                req_next.addr = instr_word[blae_pkg::ADDR_W-1:0];
                phase_next = blae_pkg::PH_READ;
            end
            blae_pkg::PH_READ:
            begin
                // file data answers the read strobe in the same clock it is high
                if (op_reg != blae_pkg::OPK_XORL)
                begin
                    opnd_next = file_rdata;
                end
                phase_next = blae_pkg::PH_PROCESS;
            end
            blae_pkg::PH_PROCESS:
            begin
                unique case (op_reg)
                    blae_pkg::OPK_ADD:
                    begin
                        result_next = sum9[7:0];
                        carry_next = sum9[8];
                        dcarry_next = sum5[4];
                    end
                    blae_pkg::OPK_AND: result_next = work_reg & opnd_reg;
                    blae_pkg::OPK_XORF: result_next = work_reg ^ opnd_reg;
                    blae_pkg::OPK_XORL: result_next = work_reg ^ opnd_reg;
                    blae_pkg::OPK_NONE: result_next = result_reg;
                endcase
                phase_next = blae_pkg::PH_WRITE;
            end
            blae_pkg::PH_WRITE:
            begin
                // literal xor always lands in work; other legal ops follow dest bit, an unknown opcode writes nothing
                if (op_reg == blae_pkg::OPK_XORL || (op_reg != blae_pkg::OPK_NONE && !dest_reg))
                begin
                    work_next = result_reg;
                end
                req_next.wr = (op_reg != blae_pkg::OPK_NONE) && (op_reg != blae_pkg::OPK_XORL)
                    && dest_reg;
                req_next.addr = addr_reg;
                req_next.wdata = result_reg;
                // only add touches carry bits; all four touch zero
                flags_next.carry_we = (op_reg == blae_pkg::OPK_ADD);
                flags_next.carry = carry_reg;
                flags_next.digit_carry_flag_we = (op_reg == blae_pkg::OPK_ADD);
                flags_next.digit_carry_flag = dcarry_reg;
                flags_next.zero_we = (op_reg != blae_pkg::OPK_NONE);
                flags_next.zero = (result_reg == 8'h00);
                done_next = (op_reg != blae_pkg::OPK_NONE);
                illegal_next = (op_reg == blae_pkg::OPK_NONE);
                phase_next = blae_pkg::PH_DECODE;
            end
        endcase
    end

    // registers only
    always_ff @(posedge core_clk or negedge rst_sync_reg)
    begin
        if (!rst_sync_reg)
        begin
            phase_reg <= blae_pkg::PH_DECODE;
            op_reg <= blae_pkg::OPK_NONE;
            dest_reg <= 1'b0;
            addr_reg <= 7'h00;
            opnd_reg <= 8'h00;
            result_reg <= 8'h00;
            carry_reg <= 1'b0;
            dcarry_reg <= 1'b0;
            work_reg <= blae_pkg::WORK_RESET;
            req_reg <= '0;
            flags_reg <= '0;
            done_reg <= 1'b0;
            illegal_reg <= 1'b0;
        end
        else
        begin
            phase_reg <= phase_next;
            op_reg <= op_next;
            dest_reg <= dest_next;
            addr_reg <= addr_next;
            opnd_reg <= opnd_next;
            result_reg <= result_next;
            carry_reg <= carry_next;
            dcarry_reg <= dcarry_next;
            work_reg <= work_next;
            req_reg <= req_next;
            flags_reg <= flags_next;
            done_reg <= done_next;
            illegal_reg <= illegal_next;
        end
    end

    // outputs straight from flops
    assign file_req = req_reg;
    assign flags_out = flags_reg;
    assign work_out = work_reg;
    assign phase_out = phase_reg;
    assign instr_done = done_reg;
    assign instr_illegal = illegal_reg;

    // ****************************************
    // checks
    // ****************************************
    // write slot, and the walk read, process, write, back to decode that must follow a decode
    sequence s_write_phase;
        phase_reg == blae_pkg::PH_WRITE;
    endsequence

    sequence s_read_to_decode;
        phase_reg == blae_pkg::PH_READ ##1 phase_reg == blae_pkg::PH_PROCESS
        ##1 phase_reg == blae_pkg::PH_WRITE ##1 phase_reg == blae_pkg::PH_DECODE;
    endsequence

    a_phase_walk: assert property (@(posedge core_clk) disable iff (!rst_sync_reg)
        phase_reg == blae_pkg::PH_DECODE |=> s_read_to_decode)
        else $error("phase order broken");

    a_add_result: assert property (@(posedge core_clk) disable iff (!rst_sync_reg)
        phase_reg == blae_pkg::PH_PROCESS && op_reg == blae_pkg::OPK_ADD
        |=> result_reg == 8'($past(work_reg) + $past(opnd_reg)))
        else $error("add result wrong");

    a_and_result: assert property (@(posedge core_clk) disable iff (!rst_sync_reg)
        phase_reg == blae_pkg::PH_PROCESS && op_reg == blae_pkg::OPK_AND
        |=> result_reg == ($past(work_reg) & $past(opnd_reg)))
        else $error("and result wrong");

    a_xorl_to_work: assert property (@(posedge core_clk) disable iff (!rst_sync_reg)
        s_write_phase ##0 (op_reg == blae_pkg::OPK_XORL) |=> work_reg == $past(result_reg) && !file_req.wr)
        else $error("literal xor not in work");

    a_xorf_result: assert property (@(posedge core_clk) disable iff (!rst_sync_reg)
        phase_reg == blae_pkg::PH_PROCESS && op_reg == blae_pkg::OPK_XORF
        |=> result_reg == ($past(work_reg) ^ $past(opnd_reg)))
        else $error("xor result wrong");

    a_dest_file: assert property (@(posedge core_clk) disable iff (!rst_sync_reg)
        s_write_phase ##0 (dest_reg && op_reg != blae_pkg::OPK_NONE && op_reg != blae_pkg::OPK_XORL)
        |=> file_req.wr && $stable(work_reg))
        else $error("file destination missed");

    a_flag_scope: assert property (@(posedge core_clk) disable iff (!rst_sync_reg)
        flags_out.carry_we |-> instr_done && $past(op_reg) == blae_pkg::OPK_ADD)
        else $error("carry touched by logic op");

    a_zero_flag: assert property (@(posedge core_clk) disable iff (!rst_sync_reg)
        flags_out.zero_we |-> flags_out.zero == (file_req.wr ? file_req.wdata == 8'h00 : work_reg == 8'h00))
        else $error("zero flag wrong");

endmodule

// *** verification/blae_tb.sv ***
`timescale 1ns/1ps
module testbench;
    logic core_clk;
    logic reset_n;
    logic [13:0] instr_word;
    logic [7:0] file_rdata;
    blae_pkg::blae_file_req_s file_req;
    blae_pkg::blae_flags_s flags_out;
    logic [7:0] work_out;
    logic [1:0] phase_out;
    logic instr_done;
    logic instr_illegal;
    int n_fail;
    int cmp_count;
    logic [7:0] w_model;

    blae_exec dut (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .instr_word(instr_word),
        .file_rdata(file_rdata),
        .file_req(file_req),
        .flags_out(flags_out),
        .work_out(work_out),
        .phase_out(phase_out),
        .instr_done(instr_done),
        .instr_illegal(instr_illegal)
    );

    // ****************************************
    // clock, checks, verdict
    // ****************************************
    // 250 MHz core clock
    initial
    begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp, input string what);
        cmp_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("mismatch t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic cmp1(input logic got, input logic exp, input string what);
        cmp8({7'h00, got}, {7'h00, exp}, what);
    endtask

    task automatic finish_test();
        $display("counts: compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // kind 0 add, 1 and, 2 xor file, 3 xor literal, 4 unknown opcode
    function automatic logic [5:0] opc(input int kind);
        case (kind)
            0: return blae_pkg::OP_ADD_WORK_TO_FILE;
            1: return blae_pkg::OP_AND_WORK_WITH_FILE;
            2: return blae_pkg::OP_XOR_WORK_WITH_FILE;
            3: return blae_pkg::OP_XOR_LITERAL_INTO_WORK;
            default: return 6'h3E;
        endcase
    endfunction

    // expected {carry, digit carry, result}
    function automatic logic [9:0] calc(input int kind, input logic [7:0] w, input logic [7:0] v);
        logic [4:0] lo;
        logic [8:0] sum;
        lo = {1'b0, w[3:0]} + {1'b0, v[3:0]};
        sum = {1'b0, w} + {1'b0, v};
        case (kind)
            0: return {sum[8], lo[4], sum[7:0]};
            1: return {2'b00, w & v};
            default: return {2'b00, w ^ v};
        endcase
    endfunction

    // ****************************************
    // one instruction through its four phases
    // ****************************************
    // entered at a falling edge; leaves at the falling edge of the next decode phase
    task automatic run_op(input int kind, input logic d, input logic [6:0] fa, input logic [7:0] fv);
        logic fop;
        logic legal;
        logic [9:0] r;
        int guard;
        fop = kind < 3;
        legal = kind < 4;
        r = calc(kind, w_model, fv);
        instr_word = fop ? {opc(kind), d, fa} : {opc(kind), fv};
        guard = 0;
        @(negedge core_clk);
        while (phase_out !== 2'h1 && guard < 8)
        begin
            guard++;
            @(negedge core_clk);
        end
        cmp8({6'h00, phase_out}, 8'h01, "read phase");
        if (legal)
            cmp1(file_req.rd, fop, "operand read");
        if (fop)
            cmp8({1'b0, file_req.addr}, {1'b0, fa}, "read addr");
        file_rdata = fv;
        @(negedge core_clk);
        // operand hold over: show the inverse so a late sample is caught
        file_rdata = ~fv;
        cmp1(file_req.rd, 1'b0, "read pulse");
        repeat (2) @(negedge core_clk);
        cmp8({6'h00, phase_out}, 8'h00, "cycle length");
        cmp1(instr_done, legal, "done");
        cmp1(instr_illegal, !legal, "unknown opcode");
        cmp1(file_req.wr, legal && fop && d, "file write");
        if (legal && fop && d)
        begin
            cmp8(file_req.wdata, r[7:0], "file data");
            cmp8({1'b0, file_req.addr}, {1'b0, fa}, "write addr");
        end
        else if (legal)
            w_model = r[7:0];
        cmp8(work_out, w_model, "work");
        cmp1(flags_out.zero_we, legal, "zero we");
        cmp1(flags_out.carry_we, kind == 0, "carry we");
        cmp1(flags_out.digit_carry_flag_we, kind == 0, "dc we");
        if (legal)
            cmp1(flags_out.zero, r[7:0] == 8'h00, "zero");
        if (kind == 0)
        begin
            cmp1(flags_out.carry, r[9], "carry");
            cmp1(flags_out.digit_carry_flag, r[8], "dc");
        end
    endtask

    // load work through the literal xor
    task automatic set_w(input logic [7:0] v);
        run_op(3, 1'b0, 7'h00, w_model ^ v);
    endtask

    task automatic rand_ops(input int n);
        repeat (n) run_op($urandom_range(4, 0), 1'(($urandom)), 7'($urandom), 8'($urandom));
        $display("test done: random %0d", n);
    endtask

    // ****************************************
    // main sequence and watchdog
    // ****************************************
    initial
    begin
        n_fail = 0;
        cmp_count = 0;
        reset_n = 1'b0;
        instr_word = 14'h0000;
        file_rdata = 8'h00;
        w_model = blae_pkg::WORK_RESET;
        void'($urandom(77));
        repeat (16) @(negedge core_clk);
        cmp8(work_out, blae_pkg::WORK_RESET, "reset work");
        reset_n = 1'b1;
        // worked examples, then carry and zero boundaries
        set_w(8'h17);
        run_op(0, 1'b0, 7'h04, 8'hC2);
        set_w(8'h17);
        run_op(1, 1'b1, 7'h04, 8'hC2);
        set_w(8'hB5);
        run_op(3, 1'b0, 7'h00, 8'hAF);
        set_w(8'hB5);
        run_op(2, 1'b1, 7'h7F, 8'hAF);
        set_w(8'hFF);
        run_op(0, 1'b1, 7'h00, 8'h01);
        set_w(8'h08);
        run_op(0, 1'b0, 7'h11, 8'h08);
        set_w(8'h80);
        run_op(0, 1'b0, 7'h12, 8'h80);
        run_op(1, 1'b0, 7'h13, 8'hFF);
        run_op(4, 1'b0, 7'h14, 8'h55);
        run_op(2, 1'b0, 7'h15, 8'h00);
        $display("test done: corners");
        rand_ops(200);
        // reset in mid-run clears work
        reset_n = 1'b0;
        repeat (3) @(negedge core_clk);
        cmp8(work_out, blae_pkg::WORK_RESET, "rerun work");
        w_model = blae_pkg::WORK_RESET;
        reset_n = 1'b1;
        rand_ops(30);
        finish_test();
    end

    // about 250 instructions of 4 cycles fit well inside this
    initial
    begin
        #20000;
        n_fail++;
        $display("mismatch t=%0t watchdog expired", $time);
        finish_test();
    end
endmodule
